/* hdl/pmae_pkg.sv */
package pmae_pkg;
  // ***************************************************
  // register byte offsets
  // ***************************************************
  localparam logic [7:0] OFS_PIN1 = 8'h00;
  localparam logic [7:0] OFS_PIN2 = 8'h04;
  localparam logic [7:0] OFS_MON = 8'h08;
  localparam logic [7:0] OFS_TRIG = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_CUR = 8'h14;
  localparam logic [7:0] OFS_VIN = 8'h18;
  localparam logic [7:0] OFS_AUX = 8'h1c;
  localparam logic [7:0] OFS_PWR = 8'h20;
  localparam logic [7:0] OFS_PWRX = 8'h24;
  localparam logic [7:0] OFS_EN = 8'h28;
  localparam logic [7:0] OFS_CNT = 8'h2c;
  localparam logic [7:0] OFS_ENX = 8'h30;
  localparam logic [7:0] OFS_ROLX = 8'h34;
  localparam logic [7:0] OFS_PK_CUR = 8'h38;
  localparam logic [7:0] OFS_PK_VIN = 8'h3c;
  localparam logic [7:0] OFS_PK_AUX = 8'h40;
  localparam logic [7:0] OFS_PK_PWR = 8'h44;
  localparam logic [7:0] OFS_VIN_OV = 8'h48;
  localparam logic [7:0] OFS_VIN_UV = 8'h4c;
  localparam logic [7:0] OFS_AUX_OV = 8'h50;
  localparam logic [7:0] OFS_AUX_UV = 8'h54;
  localparam logic [7:0] OFS_CUR_OC = 8'h58;
  localparam logic [7:0] OFS_PWR_OP = 8'h5c;
  // ***************************************************
  // widths, reset values, status bit positions
  // ***************************************************
  localparam int SMP_W = 12;
  localparam int PWR_W = 24;
  localparam int ROL_W = 16;
  localparam int NST = 6;
  localparam logic [11:0] LIM_MAX = 12'hfff;
  localparam logic [11:0] LIM_MIN = 12'h000;
  localparam logic [15:0] PWR_MAX = 16'hffff;
  localparam logic [22:0] ACC_MAX = 23'h7fffff;
  localparam int ST_VIN_OV = 0;
  localparam int ST_VIN_UV = 1;
  localparam int ST_AUX_OV = 2;
  localparam int ST_AUX_UV = 3;
  localparam int ST_CUR_OC = 4;
  localparam int ST_PWR_OP = 5;
  // adc channel codes
  localparam logic [1:0] CH_CUR = 2'h0;
  localparam logic [1:0] CH_VIN = 2'h1;
  localparam logic [1:0] CH_AUX = 2'h2;
  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [1:0] {
    PM_ALERT = 2'h0,
    PM_GPO = 2'h1,
    PM_CONVERT_TRIGGER_INPUT = 2'h2
  } pmae_pin_mode_t;
  typedef struct packed {
    logic [7:0] mask;
    logic [4:0] spare;
    logic level;
    pmae_pin_mode_t mode;
  } pmae_pin_setup_t;
  typedef struct packed {
    logic [2:0] v_avg;
    logic [2:0] i_avg;
    logic range;
    logic aux_en;
    logic cont;
  } pmae_mon_setup_t;
endpackage

/* hdl/pmae_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: each multipurpose pin is gpo or alert; pin one can also be convert input
// R2: alert asserts when any masked status set
// R3: gpo mode drives level, ignores mask
// R4: pin one convert mode ignores gpo, mask
// R5: convert pin rising starts one single shot
// R6: current, voltage always sampled; aux if enabled
// R7: setup picks mode, aux, range, averaging
// R8: host avoids setup changes while sampling
// R9: software command starts single or continuous
// R10: power is voltage times positive current
// R11: extended power 24 bits, standard top 16
// R12: power adds to accumulator; wrap counts rollover
// R13: rollover counter wraps after full scale
// R14: sample counter counts each accumulation
// R15: standard energy: top16, low8 rollover, count
// R16: extended energy: all accumulator, rollover, count
// R17: host reads energy before double rollover
// R18: peaks hold highest readings since clear
// R19: peaks update only after averaging pass
// R20: writing zero clears one peak only
// R21: warnings need strictly above or below
// R22: limits reset to disable all warnings
// R23: warnings latch; clear redone if active
// R24: compare averaged values when readings update
// R25: single shot does one pass then idles
module pmae_top #(
  parameter int AVG_LOG_W = 3
) (
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // converter handshake
  output logic O_ADC_REQ,
  output logic [1:0] O_ADC_CHAN,
  output logic O_ADC_RANGE,
  input wire logic I_ADC_VALID,
  input wire logic [11:0] I_ADC_DATA,
  // multipurpose pins
  input wire logic I_MP1_IN,
  output logic O_MP1_OUT,
  output logic O_MP1_OE,
  output logic O_MP2_OUT,
  output logic O_MP2_OE
);
  localparam int SUM_W = pmae_pkg::SMP_W + (1 << AVG_LOG_W) - 1;
  localparam logic [7:0] ONE8 = 8'h01;

  // ***************************************************
  // helpers
  // ***************************************************
  // averaged value from a running sum
  function automatic logic [11:0] avg_of(input logic [SUM_W-1:0] s,
                                         input logic [2:0] sh);
    logic [SUM_W-1:0] t;
    t = s >> sh;
    avg_of = t[11:0];
  endfunction

  // alert level of one pin from its setup
  function automatic logic alert_of(input pmae_pkg::pmae_pin_setup_t p,
                                    input logic [5:0] st);
    alert_of = |(p.mask[5:0] & st);
  endfunction

  typedef enum {S_IDLE, S_REQ, S_WAIT, S_CALC} pmae_state_t;

  pmae_pkg::pmae_pin_setup_t pin1_reg, pin2_reg;
  pmae_pkg::pmae_mon_setup_t mon_reg;
  pmae_state_t state_reg;
  logic run_reg, start_req, stop_req, convert_trigger_input_prev_reg, convert_trigger_input_rise;
  logic [1:0] chan_reg;
  logic [7:0] idx_reg, n_tot, n_cur, n_vlt;
  logic [SUM_W-1:0] sum_cur_reg, sum_vin_reg, sum_aux_reg;
  logic [11:0] cur_reg, vin_reg, aux_reg;
  logic [11:0] a_cur, a_vin, a_aux, cur_pos;
  logic [23:0] pwr_reg, pwr_next;
  logic [22:0] acc_reg;
  logic [23:0] acc_sum;
  logic [15:0] rol_reg;
  logic [23:0] cnt_reg;
  logic [11:0] pk_cur_reg, pk_vin_reg, pk_aux_reg;
  logic [23:0] pk_pwr_reg;
  logic [11:0] vin_ov_reg, vin_uv_reg, aux_ov_reg, aux_uv_reg;
  logic [11:0] cur_oc_reg;
  logic [15:0] pwr_op_reg;
  logic [5:0] stat_reg, cond_reg, cond_next;
  logic [31:0] rdata_reg, rdata_next;
  logic setup_ph, wr_en, mapped, calc;

  // ***************************************************
  // apb decode
  // ***************************************************
  // zero-wait slave: read data captured in setup phase
  assign setup_ph = I_PSEL & ~I_PENABLE;
  assign wr_en = I_CE & I_PSEL & I_PENABLE & I_PWRITE;
  assign O_PREADY = I_PSEL & I_PENABLE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
  assign O_PRDATA = rdata_reg;

  // read mux, also flags mapped addresses
  always_comb begin
    mapped = 1'b1;
    rdata_next = 32'h0000_0000;
    case (I_PADDR)
      pmae_pkg::OFS_PIN1: rdata_next = {16'h0000, pin1_reg};
      pmae_pkg::OFS_PIN2: rdata_next = {16'h0000, pin2_reg};
      pmae_pkg::OFS_MON: rdata_next = {23'h000000, mon_reg};
      pmae_pkg::OFS_TRIG: rdata_next = {30'h00000000, run_reg,
                                        state_reg != S_IDLE};
      pmae_pkg::OFS_STAT: rdata_next = {26'h0000000, stat_reg};
      pmae_pkg::OFS_CUR: rdata_next = {20'h00000, cur_reg};
      pmae_pkg::OFS_VIN: rdata_next = {20'h00000, vin_reg};
      pmae_pkg::OFS_AUX: rdata_next = {20'h00000, aux_reg};
      // standard power: top 16 bits, msb zero [R11]
      pmae_pkg::OFS_PWR: rdata_next = {16'h0000, pwr_reg[23:8]};
      pmae_pkg::OFS_PWRX: rdata_next = {8'h00, pwr_reg}; // [R11]
      // standard energy: rollover low byte and top 16 [R15]
      pmae_pkg::OFS_EN: rdata_next = {8'h00, rol_reg[7:0],
                                      1'b0, acc_reg[22:8]};
      pmae_pkg::OFS_CNT: rdata_next = {8'h00, cnt_reg}; // [R15] [R16]
      pmae_pkg::OFS_ENX: rdata_next = {9'h000, acc_reg}; // [R16]
      pmae_pkg::OFS_ROLX: rdata_next = {16'h0000, rol_reg}; // [R16]
      pmae_pkg::OFS_PK_CUR: rdata_next = {20'h00000, pk_cur_reg};
      pmae_pkg::OFS_PK_VIN: rdata_next = {20'h00000, pk_vin_reg};
      pmae_pkg::OFS_PK_AUX: rdata_next = {20'h00000, pk_aux_reg};
      pmae_pkg::OFS_PK_PWR: rdata_next = {8'h00, pk_pwr_reg};
      pmae_pkg::OFS_VIN_OV: rdata_next = {20'h00000, vin_ov_reg};
      pmae_pkg::OFS_VIN_UV: rdata_next = {20'h00000, vin_uv_reg};
      pmae_pkg::OFS_AUX_OV: rdata_next = {20'h00000, aux_ov_reg};
      pmae_pkg::OFS_AUX_UV: rdata_next = {20'h00000, aux_uv_reg};
      pmae_pkg::OFS_CUR_OC: rdata_next = {20'h00000, cur_oc_reg};
      pmae_pkg::OFS_PWR_OP: rdata_next = {16'h0000, pwr_op_reg};
      default: mapped = 1'b0;
    endcase
  end

  // read data register
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (I_CE && setup_ph) begin
      rdata_reg <= rdata_next;
    end
  end

  // ***************************************************
  // setup registers and limits
  // ***************************************************
  // host keeps setup steady while sampling; not enforced [R8]
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pin1_reg <= '0;
      pin2_reg <= '0;
      mon_reg <= '0;
    end else if (wr_en) begin
      case (I_PADDR)
        pmae_pkg::OFS_PIN1: pin1_reg <= I_PWDATA[15:0]; // [R1]
        pmae_pkg::OFS_PIN2: pin2_reg <= I_PWDATA[15:0]; // [R1]
        pmae_pkg::OFS_MON: mon_reg <= I_PWDATA[8:0]; // [R7]
        default: ;
      endcase
    end
  end

  // limits start fully open so nothing warns [R22]
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      vin_ov_reg <= pmae_pkg::LIM_MAX; // [R22]
      vin_uv_reg <= pmae_pkg::LIM_MIN;
      aux_ov_reg <= pmae_pkg::LIM_MAX;
      aux_uv_reg <= pmae_pkg::LIM_MIN;
      cur_oc_reg <= pmae_pkg::LIM_MAX;
      pwr_op_reg <= pmae_pkg::PWR_MAX;
    end else if (wr_en) begin
      case (I_PADDR)
        pmae_pkg::OFS_VIN_OV: vin_ov_reg <= I_PWDATA[11:0];
        pmae_pkg::OFS_VIN_UV: vin_uv_reg <= I_PWDATA[11:0];
        pmae_pkg::OFS_AUX_OV: aux_ov_reg <= I_PWDATA[11:0];
        pmae_pkg::OFS_AUX_UV: aux_uv_reg <= I_PWDATA[11:0];
        pmae_pkg::OFS_CUR_OC: cur_oc_reg <= I_PWDATA[11:0];
        pmae_pkg::OFS_PWR_OP: pwr_op_reg <= I_PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // ***************************************************
  // multipurpose pins
  // ***************************************************
  // pin one in convert mode is input only [R4]
  assign O_MP1_OE = (pin1_reg.mode != pmae_pkg::PM_CONVERT_TRIGGER_INPUT); // [R4]
  assign O_MP2_OE = 1'b1;
  always_comb begin
    case (pin1_reg.mode)
      pmae_pkg::PM_GPO: O_MP1_OUT = pin1_reg.level; // [R3]
      pmae_pkg::PM_ALERT: O_MP1_OUT = alert_of(pin1_reg, stat_reg); // [R2]
      default: O_MP1_OUT = 1'b0; // [R4]
    endcase
    // pin two has no convert mode; treat it as alert
    if (pin2_reg.mode == pmae_pkg::PM_GPO) begin
      O_MP2_OUT = pin2_reg.level; // [R3]
    end else begin
      O_MP2_OUT = alert_of(pin2_reg, stat_reg); // [R2]
    end
  end

  // convert edge, input taken as synchronous
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      convert_trigger_input_prev_reg <= 1'b0;
    end else if (I_CE) begin
      convert_trigger_input_prev_reg <= I_MP1_IN;
    end
  end
  assign convert_trigger_input_rise = (pin1_reg.mode == pmae_pkg::PM_CONVERT_TRIGGER_INPUT) &
                     I_MP1_IN & ~convert_trigger_input_prev_reg; // [R5]

  // ***************************************************
  // sampling sequencer
  // ***************************************************
  // trigger command: bit0 high starts, low stops continuous
  assign start_req = (wr_en && I_PADDR == pmae_pkg::OFS_TRIG &&
                      I_PWDATA[0]) || (I_CE && convert_trigger_input_rise); // [R9] [R5]
  assign stop_req = wr_en && I_PADDR == pmae_pkg::OFS_TRIG &&
                    !I_PWDATA[0];
  // pass length follows the longer of the two averages
  assign n_cur = ONE8 << mon_reg.i_avg;
  assign n_vlt = ONE8 << mon_reg.v_avg;
  assign n_tot = (n_cur > n_vlt) ? n_cur : n_vlt;
  assign calc = I_CE && state_reg == S_CALC;
  assign O_ADC_REQ = (state_reg == S_REQ);
  assign O_ADC_CHAN = chan_reg;
  assign O_ADC_RANGE = mon_reg.range; // [R7]

  // run flag: continuous only while software keeps it on
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      run_reg <= 1'b0;
    end else if (stop_req) begin
      run_reg <= 1'b0;
    end else if (wr_en && I_PADDR == pmae_pkg::OFS_TRIG) begin
      run_reg <= mon_reg.cont; // [R9]
    end else if (I_CE && convert_trigger_input_rise) begin
      run_reg <= 1'b0; // convert is single shot unless a trigger write shares the cycle [R5]
    end
  end

  // pass state machine
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_reg <= S_IDLE;
      chan_reg <= pmae_pkg::CH_CUR;
      idx_reg <= 8'h00;
    end else if (I_CE) begin
      case (state_reg)
        S_IDLE: begin
          chan_reg <= pmae_pkg::CH_CUR;
          idx_reg <= 8'h00;
          if (start_req) begin
            state_reg <= S_REQ;
          end
        end
        S_REQ: state_reg <= S_WAIT;
        S_WAIT: begin
          if (I_ADC_VALID) begin
            // current then voltage, aux only if enabled [R6]
            if (chan_reg == pmae_pkg::CH_CUR) begin
              chan_reg <= pmae_pkg::CH_VIN;
              state_reg <= S_REQ;
            end else if (chan_reg == pmae_pkg::CH_VIN &&
                         mon_reg.aux_en) begin
              chan_reg <= pmae_pkg::CH_AUX;
              state_reg <= S_REQ;
            end else if (idx_reg + ONE8 < n_tot) begin
              chan_reg <= pmae_pkg::CH_CUR;
              idx_reg <= idx_reg + ONE8;
              state_reg <= S_REQ;
            end else begin
              state_reg <= S_CALC;
            end
          end
        end
        S_CALC: begin
          chan_reg <= pmae_pkg::CH_CUR;
          idx_reg <= 8'h00;
          // single shot ends after one pass [R25]
          state_reg <= (run_reg && !stop_req) ? S_REQ : S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // running sums; current over its own count, voltage and aux over the voltage count [R7]
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sum_cur_reg <= '0;
      sum_vin_reg <= '0;
      sum_aux_reg <= '0;
    end else if (calc || (I_CE && state_reg == S_IDLE)) begin
      sum_cur_reg <= '0;
      sum_vin_reg <= '0;
      sum_aux_reg <= '0;
    end else if (I_CE && state_reg == S_WAIT && I_ADC_VALID) begin
      if (chan_reg == pmae_pkg::CH_CUR && idx_reg < n_cur) begin
        sum_cur_reg <= sum_cur_reg + SUM_W'(I_ADC_DATA);
      end
      if (chan_reg == pmae_pkg::CH_VIN && idx_reg < n_vlt) begin
        sum_vin_reg <= sum_vin_reg + SUM_W'(I_ADC_DATA);
      end
      if (chan_reg == pmae_pkg::CH_AUX && idx_reg < n_vlt) begin
        sum_aux_reg <= sum_aux_reg + SUM_W'(I_ADC_DATA);
      end
    end
  end

  // ***************************************************
  // readings, power, energy
  // ***************************************************
  assign a_cur = avg_of(sum_cur_reg, mon_reg.i_avg);
  assign a_vin = avg_of(sum_vin_reg, mon_reg.v_avg);
  assign a_aux = avg_of(sum_aux_reg, mon_reg.v_avg);
  // negative current gives zero power [R10]
  assign cur_pos = a_cur[11] ? 12'h000 : a_cur; // [R10]
  assign pwr_next = a_vin * cur_pos; // [R10]
  assign acc_sum = {1'b0, acc_reg} + pwr_next; // [R12]

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      cur_reg <= 12'h000;
      vin_reg <= 12'h000;
      aux_reg <= 12'h000;
      pwr_reg <= 24'h000000;
    end else if (calc) begin
      cur_reg <= a_cur;
      vin_reg <= a_vin;
      if (mon_reg.aux_en) begin
        aux_reg <= a_aux; // [R6]
      end
      pwr_reg <= pwr_next; // [R10]
    end
  end

  // accumulator keeps msb zero; overflow past max counts [R12]
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      acc_reg <= 23'h000000;
      rol_reg <= 16'h0000;
      cnt_reg <= 24'h000000;
    end else if (calc) begin
      acc_reg <= acc_sum[22:0]; // [R12]
      if (acc_sum > {1'b0, pmae_pkg::ACC_MAX}) begin
        rol_reg <= rol_reg + 16'h0001; // free wrap at full scale [R13]
      end
      cnt_reg <= cnt_reg + 24'h000001; // [R14]
    end
  end
  // host must poll faster than two rollovers [R17]

  // ***************************************************
  // peaks
  // ***************************************************
  // averaged values only, never raw samples [R18] [R19]
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pk_cur_reg <= 12'h000;
      pk_vin_reg <= 12'h000;
      pk_aux_reg <= 12'h000;
      pk_pwr_reg <= 24'h000000;
    end else if (calc) begin
      if (a_cur > pk_cur_reg) pk_cur_reg <= a_cur; // [R18] [R19]
      if (a_vin > pk_vin_reg) pk_vin_reg <= a_vin;
      if (mon_reg.aux_en && a_aux > pk_aux_reg) pk_aux_reg <= a_aux;
      if (pwr_next > pk_pwr_reg) pk_pwr_reg <= pwr_next;
    end else if (wr_en && I_PWDATA == 32'h0000_0000) begin
      // zero write clears only the addressed peak [R20]
      case (I_PADDR)
        pmae_pkg::OFS_PK_CUR: pk_cur_reg <= 12'h000;
        pmae_pkg::OFS_PK_VIN: pk_vin_reg <= 12'h000;
        pmae_pkg::OFS_PK_AUX: pk_aux_reg <= 12'h000;
        pmae_pkg::OFS_PK_PWR: pk_pwr_reg <= 24'h000000;
        default: ;
      endcase
    end
  end

  // ***************************************************
  // warnings
  // ***************************************************
  // strict compare against averaged values at update [R21] [R24]
  always_comb begin
    cond_next = 6'h00;
    cond_next[pmae_pkg::ST_VIN_OV] = a_vin > vin_ov_reg; // [R21]
    cond_next[pmae_pkg::ST_VIN_UV] = a_vin < vin_uv_reg; // [R21]
    cond_next[pmae_pkg::ST_AUX_OV] = mon_reg.aux_en && a_aux > aux_ov_reg;
    cond_next[pmae_pkg::ST_AUX_UV] = mon_reg.aux_en && a_aux < aux_uv_reg;
    cond_next[pmae_pkg::ST_CUR_OC] = a_cur > cur_oc_reg;
    cond_next[pmae_pkg::ST_PWR_OP] = pwr_next[23:8] > pwr_op_reg;
  end

  // last compared condition, kept so a clear can re-set
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      cond_reg <= 6'h00;
    end else if (calc) begin
      cond_reg <= cond_next; // [R24]
    end
  end

  // latched status, write one to clear; set beats clear [R23]
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      stat_reg <= 6'h00;
    end else if (I_CE) begin
      stat_reg <= (stat_reg & ~((wr_en && I_PADDR == pmae_pkg::OFS_STAT)
                  ? I_PWDATA[5:0] : 6'h00)) | cond_reg |
                  (calc ? cond_next : 6'h00); // [R23] [R24]
    end
  end
endmodule
`default_nettype wire

/* bench/pmae_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port-level checks for the monitor
// ****************************************
module pmae_properties (
  // clock, reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // apb
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // converter
  input wire logic O_ADC_REQ,
  input wire logic [1:0] O_ADC_CHAN,
  input wire logic I_ADC_VALID,
  // pins
  input wire logic I_MP1_IN,
  input wire logic O_MP1_OE,
  input wire logic O_MP2_OE
);
  logic [1:0] last_ch_reg;
  logic wait_reg;
  // channel in flight; a second request before the answer would be lost
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      last_ch_reg <= pmae_pkg::CH_AUX;
      wait_reg <= 1'b0;
    end else if (O_ADC_REQ) begin
      last_ch_reg <= O_ADC_CHAN;
      wait_reg <= 1'b1;
    end else if (I_ADC_VALID) begin
      wait_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  AST_READY: assert property (O_PREADY == (I_PSEL && I_PENABLE))
    else $error("pready not zero wait");
  AST_ERR: assert property (O_PSLVERR |-> O_PREADY)
    else $error("pslverr outside access");
  AST_REQ_ONE: assert property (O_ADC_REQ |=> !O_ADC_REQ)
    else $error("request longer than one cycle");
  AST_NO_OVERLAP: assert property (O_ADC_REQ |-> !wait_reg)
    else $error("request while waiting");
  AST_CHAN_HOLD: assert property (wait_reg && !I_ADC_VALID |=>
    $stable(O_ADC_CHAN)) else $error("channel moved");
  AST_VIN_ORDER: assert property (O_ADC_REQ && O_ADC_CHAN ==
    pmae_pkg::CH_VIN |-> last_ch_reg == pmae_pkg::CH_CUR)
    else $error("voltage not after current");
  AST_AUX_ORDER: assert property (O_ADC_REQ && O_ADC_CHAN ==
    pmae_pkg::CH_AUX |-> last_ch_reg == pmae_pkg::CH_VIN)
    else $error("aux not after voltage");
  AST_CHAN_OK: assert property (O_ADC_REQ |-> O_ADC_CHAN != 2'h3)
    else $error("bad channel");
  AST_MP2_OE: assert property (O_MP2_OE)
    else $error("pin two not driven");
  AST_CONVERT_TRIGGER_INPUT: assert property (!O_MP1_OE && $rose(I_MP1_IN) |->
    ##[1:8] O_ADC_REQ) else $error("convert edge ignored");
  COV_CONVERT_TRIGGER_INPUT: cover property (!O_MP1_OE && $rose(I_MP1_IN));
  COV_AUX: cover property (O_ADC_REQ && O_ADC_CHAN == pmae_pkg::CH_AUX);
  COV_ERR: cover property (O_PSLVERR);
endmodule
`default_nettype wire

/* bench/pmae_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// converter stand-in, answer after dly
// ****************************************
module pmae_adc_model (
  // clock, reset
  input wire logic clk,
  input wire logic rst,
  // request side
  input wire logic req,
  input wire logic [1:0] chan,
  input wire logic [3:0] dly,
  input wire logic [11:0] cv,
  input wire logic [11:0] vv,
  input wire logic [11:0] av,
  // answer
  output logic valid,
  output logic [11:0] data
);
  logic busy;
  logic [1:0] ch;
  logic [3:0] n;
  // idle data toggles so a stale word never looks valid
  always_ff @(posedge clk) begin
    valid <= 1'b0;
    data <= ~data;
    if (rst) begin
      busy <= 1'b0;
      data <= 12'ha5a;
    end else if (req) begin
      busy <= 1'b1;
      ch <= chan;
      n <= dly;
    end else if (busy && n == 4'h0) begin
      busy <= 1'b0;
      valid <= 1'b1;
      data <= (ch == 2'h0) ? cv : (ch == 2'h1) ? vv : av;
    end else if (busy) begin
      n <= n - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* bench/pmae_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module pmae_top_tb;
  typedef struct packed {
    logic [11:0] c, v, x;
    logic [31:0] m;
    logic [23:0] p;
  } pmae_row_t;
  pmae_row_t rows [4] = '{
    '{12'h7ff, 12'hfff, 12'h123, 32'h002, 24'h7fe801},
    '{12'h800, 12'h800, 12'h456, 32'h08a, 24'h000000},
    '{12'h7ff, 12'hfff, 12'h0aa, 32'h006, 24'h7fe801},
    '{12'h012, 12'h345, 12'h7ff, 32'h1c2, 24'h003ada}};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic mp1i = 1'b0, rdy, err, req, vld, mp1o, mp1e, mp2o;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q;
  logic [1:0] ch;
  logic [11:0] adat, cv = 12'h0, vv = 12'h0, av = 12'h0;
  logic [3:0] dly = 4'h0;
  logic [22:0] acc = 23'h0;
  logic [15:0] rol = 16'h0;
  logic [23:0] cnt = 24'h0;
  logic cy, e;
  int errors = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  pmae_top pmae_top_i (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa),
    .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
    .O_ADC_REQ(req), .O_ADC_CHAN(ch), .O_ADC_RANGE(),
    .I_ADC_VALID(vld), .I_ADC_DATA(adat), .I_MP1_IN(mp1i),
    .O_MP1_OUT(mp1o), .O_MP1_OE(mp1e), .O_MP2_OUT(mp2o), .O_MP2_OE());
  pmae_adc_model pmae_adc_model_i (.clk(clk), .rst(rst), .req(req),
    .chan(ch), .dly(dly), .cv(cv), .vv(vv), .av(av), .valid(vld),
    .data(adat));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end
  // one apb transfer; request held until pready seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    q = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // polls busy, bounded; setup written without waiting for idle
  task run(input logic [31:0] m);
    int n;
    apb(1'b1, pmae_pkg::OFS_MON, m);
    apb(1'b1, pmae_pkg::OFS_TRIG, 32'h1);
    n = 0;
    do begin
      apb(1'b0, pmae_pkg::OFS_TRIG, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    cnt++;
  endtask
  task pin(input logic [31:0] d, input logic exp);
    apb(1'b1, pmae_pkg::OFS_PIN2, d);
    repeat (2) @(posedge clk);
    chk({31'h0, mp2o}, {31'h0, exp});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc(pmae_pkg::OFS_VIN_OV, 32'hfff);
    rc(pmae_pkg::OFS_VIN_UV, 32'h0);
    rc(pmae_pkg::OFS_PWR_OP, 32'hffff);
    chk({30'h0, mp1o, mp2o}, 32'h0);
    $display("reset test done");
    // energy read after every pass, so at most one wrap between
    for (int i = 0; i < 4; i++) begin
      cv <= rows[i].c;
      vv <= rows[i].v;
      av <= rows[i].x;
      dly <= 4'(3 * i);
      run(rows[i].m);
      {cy, acc} = 24'(acc) + rows[i].p;
      rol = rol + 16'(cy);
      rc(pmae_pkg::OFS_CUR, {20'h0, rows[i].c});
      rc(pmae_pkg::OFS_VIN, {20'h0, rows[i].v});
      rc(pmae_pkg::OFS_AUX, {20'h0, rows[i].x});
      rc(pmae_pkg::OFS_PWRX, {8'h0, rows[i].p});
      rc(pmae_pkg::OFS_PWR, {16'h0, rows[i].p[23:8]});
      rc(pmae_pkg::OFS_ENX, {9'h0, acc});
      rc(pmae_pkg::OFS_ROLX, {16'h0, rol});
      rc(pmae_pkg::OFS_CNT, {8'h0, cnt});
      rc(pmae_pkg::OFS_EN, {8'h0, rol[7:0], 1'b0, acc[22:8]});
      $display("row %0d done", i);
    end
    rc(pmae_pkg::OFS_STAT, 32'h0);
    rc(pmae_pkg::OFS_PK_VIN, 32'hfff);
    apb(1'b1, pmae_pkg::OFS_PK_VIN, 32'h0);
    rc(pmae_pkg::OFS_PK_VIN, 32'h0);
    rc(pmae_pkg::OFS_PK_AUX, 32'h7ff);
    $display("peak test done");
    apb(1'b1, pmae_pkg::OFS_VIN_OV, 32'h345);
    apb(1'b1, pmae_pkg::OFS_VIN_UV, 32'h345);
    run(32'h2);
    rc(pmae_pkg::OFS_STAT, 32'h0);
    apb(1'b1, pmae_pkg::OFS_VIN_OV, 32'h344);
    apb(1'b1, pmae_pkg::OFS_CUR_OC, 32'h011);
    run(32'h2);
    rc(pmae_pkg::OFS_STAT, 32'h11);
    pin(32'h100, 1'b1); // alert on masked bit
    pin(32'hff01, 1'b0); // gpo low despite mask
    pin(32'h0005, 1'b1); // gpo high
    apb(1'b1, pmae_pkg::OFS_VIN_OV, 32'hfff);
    apb(1'b1, pmae_pkg::OFS_CUR_OC, 32'hfff);
    run(32'h2);
    rc(pmae_pkg::OFS_STAT, 32'h11);
    apb(1'b1, pmae_pkg::OFS_STAT, 32'h11);
    rc(pmae_pkg::OFS_STAT, 32'h0);
    $display("limit and pin test done");
    apb(1'b1, pmae_pkg::OFS_PIN1, 32'hff06);
    repeat (2) @(posedge clk);
    chk({31'h0, mp1e}, 32'h0);
    mp1i <= 1'b1;
    repeat (300) @(posedge clk);
    mp1i <= 1'b0;
    cnt++;
    rc(pmae_pkg::OFS_CNT, {8'h0, cnt});
    apb(1'b0, 8'h60, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("convert and bus test done");
    apb(1'b1, pmae_pkg::OFS_MON, 32'h1);
    apb(1'b1, pmae_pkg::OFS_TRIG, 32'h1);
    repeat (400) @(posedge clk);
    run(32'h1);
    apb(1'b1, pmae_pkg::OFS_TRIG, 32'h0);
    repeat (100) @(posedge clk);
    apb(1'b0, pmae_pkg::OFS_CNT, 32'h0);
    chk({q[31:24], 24'h0}, 32'h0);
    chk({31'h0, q[23:0] > cnt + 24'h4}, 32'h1);
    cnt = q[23:0];
    repeat (100) @(posedge clk);
    rc(pmae_pkg::OFS_CNT, {8'h0, cnt});
    $display("continuous test done");
    wrap_up();
  end
endmodule
bind pmae_top pmae_properties pmae_properties_i (.I_CLK(I_CLK),
  .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_ADC_REQ(O_ADC_REQ),
  .O_ADC_CHAN(O_ADC_CHAN), .I_ADC_VALID(I_ADC_VALID),
  .I_MP1_IN(I_MP1_IN), .O_MP1_OE(O_MP1_OE), .O_MP2_OE(O_MP2_OE));
`default_nettype wire
